// ==== bfc_pkg.sv ====
`default_nettype none
package bfc_pkg;
    // --------------------------------------------------------------
    // Initialization byte layout and request codes
    // --------------------------------------------------------------
    localparam int INIT_TYPE_BIT = 7;
    localparam logic [2:0] REQ_SGL_RD = 3'h0;
    localparam logic [2:0] REQ_SGL_WR = 3'h1;
    localparam logic [2:0] REQ_STK_RD = 3'h2;
    localparam logic [2:0] REQ_STK_WR = 3'h3;
    localparam logic [2:0] REQ_BC_RD = 3'h4;
    localparam logic [2:0] REQ_BC_WR = 3'h5;
    localparam logic [2:0] REQ_BC_WRR = 3'h6;
    localparam logic [2:0] REQ_RSVD = 3'h7;
    // --------------------------------------------------------------
    // Address byte, sizes and frame overhead
    // --------------------------------------------------------------
    localparam logic [5:0] DEV_ADDR_MAX = 6'h3f;
    localparam logic [7:0] DEV_ALIAS_LO = 8'h4f;
    localparam int MAX_WR_BYTES = 8;
    localparam int MAX_RSP_BYTES = 128;
    localparam logic [7:0] RSP_OVERHEAD = 8'h07;
    localparam logic [7:0] RD_INVALID_DATA = 8'h00;
    // --------------------------------------------------------------
    // CRC-16, LSB-first stream, reflected form of x16+x15+x2+1
    // --------------------------------------------------------------
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_STREAM = 16'hc002;
    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // One byte through the serial divider, bit 0 first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ b[i])
                r = (r >> 1) ^ CRC_POLY_REFL;
            else
                r = r >> 1;
        end
        return r;
    endfunction

    // Only single-device requests carry a device-address byte
    function automatic logic has_dev(input logic [2:0] req);
        return (req == REQ_SGL_RD) || (req == REQ_SGL_WR);
    endfunction

    function automatic logic is_read(input logic [2:0] req);
        return (req == REQ_SGL_RD) || (req == REQ_STK_RD) || (req == REQ_BC_RD);
    endfunction

    // Whole command frame length in bytes, CRC included
    function automatic logic [7:0] cmd_len(input logic [2:0] req, input logic [2:0] size);
        logic [7:0] n;
        n = is_read(req) ? 8'h01 : ({5'h00, size} + 8'h01);
        return (has_dev(req) ? 8'h02 : 8'h01) + 8'h04 + n;
    endfunction

    function automatic logic [7:0] rsp_len(input logic [6:0] cnt);
        return {1'b0, cnt} + RSP_OVERHEAD;
    endfunction
endpackage
`default_nettype wire

// ==== bfc_link_if.sv ====
`default_nettype none
// Byte-wide frame link: commands toward the device, responses back
interface bfc_link_if;
    logic cmd_vld;
    logic cmd_sof;
    logic cmd_err;
    logic [7:0] cmd_byte;
    logic rsp_vld;
    logic rsp_sof;
    logic [7:0] rsp_byte;

    modport host (
        output cmd_vld, cmd_sof, cmd_err, cmd_byte,
        input rsp_vld, rsp_sof, rsp_byte
    );
    modport device (
        input cmd_vld, cmd_sof, cmd_err, cmd_byte,
        output rsp_vld, rsp_sof, rsp_byte
    );
endinterface
`default_nettype wire

// ==== bfc_host_end.sv ====
`default_nettype none
module bfc_host_end (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    bfc_link_if.host link,
    input wire logic I_START,
    input wire logic [2:0] I_REQ,
    input wire logic [5:0] I_DEV_ADDR,
    input wire logic [15:0] I_REG_ADDR,
    input wire logic [2:0] I_SIZE,
    input wire logic [63:0] I_DATA,
    input wire logic I_MARK_ERR,
    output var logic O_BUSY,
    output var logic O_RSP_VLD,
    output var logic O_RSP_SOF,
    output var logic [7:0] O_RSP_BYTE,
    output var logic O_RSP_END,
    output var logic O_RSP_CRC_OK
);
    logic busy_ff, err_ff, vld_ff, sof_ff, cerr_ff;
    logic [2:0] req_ff, size_ff;
    logic [5:0] dev_ff;
    logic [15:0] reg_ff, crc_ff;
    logic [63:0] dat_ff;
    logic [7:0] idx_ff, len_ff, byte_ff, sel, hdr, d;
    logic [7:0] r_idx_ff, r_len_ff, r_idx;
    logic [15:0] r_crc_ff, r_crc_nx;
    logic r_act_ff;

    // --------------------------------------------------------------
    // Command frame builder
    // --------------------------------------------------------------
    assign hdr = bfc_pkg::has_dev(req_ff) ? 8'h02 : 8'h01;
    assign d = idx_ff - hdr - 8'h02;

    // Byte at the current position, fixed field order
    always_comb
    begin
        if (idx_ff == 8'h00)
            sel = {1'b1, req_ff, 1'b0, size_ff};
        else if (idx_ff < hdr)
            sel = {2'b00, dev_ff};
        else if (idx_ff == hdr)
            sel = reg_ff[15:8];
        else if (idx_ff == hdr + 8'h01)
            sel = reg_ff[7:0];
        else if (idx_ff < len_ff - 8'h02)
            sel = dat_ff[{d[2:0], 3'b000} +: 8];
        else if (idx_ff == len_ff - 8'h02)
            sel = crc_ff[7:0];
        else
            sel = crc_ff[15:8];
    end

    // Latch a request and walk its bytes one per cycle
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            busy_ff <= 1'b0;
            vld_ff <= 1'b0;
            sof_ff <= 1'b0;
            cerr_ff <= 1'b0;
            byte_ff <= 8'h00;
            idx_ff <= 8'h00;
            len_ff <= 8'h00;
            crc_ff <= bfc_pkg::CRC_INIT;
            req_ff <= 3'h0;
            size_ff <= 3'h0;
            dev_ff <= 6'h00;
            reg_ff <= 16'h0000;
            dat_ff <= 64'h0;
            err_ff <= 1'b0;
        end
        else if (!busy_ff)
        begin
            vld_ff <= 1'b0;
            sof_ff <= 1'b0;
            cerr_ff <= 1'b0;
            if (I_START)
            begin
                busy_ff <= 1'b1;
                idx_ff <= 8'h00;
                crc_ff <= bfc_pkg::CRC_INIT;
                req_ff <= I_REQ;
                size_ff <= bfc_pkg::is_read(I_REQ) ? 3'h0 : I_SIZE;
                dev_ff <= I_DEV_ADDR;
                reg_ff <= I_REG_ADDR;
                dat_ff <= I_DATA;
                err_ff <= I_MARK_ERR;
                len_ff <= bfc_pkg::cmd_len(I_REQ, I_SIZE);
            end
        end
        else
        begin
            vld_ff <= 1'b1;
            sof_ff <= (idx_ff == 8'h00);
            cerr_ff <= err_ff;
            byte_ff <= sel;
            // CRC over non-CRC bytes
            // Folding in the low CRC byte would zero the high one
            if (idx_ff < len_ff - 8'h02)
                crc_ff <= bfc_pkg::crc_byte(crc_ff, sel);
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff == len_ff - 8'h01)
                busy_ff <= 1'b0;
        end
    end

    assign link.cmd_vld = vld_ff;
    assign link.cmd_sof = sof_ff;
    assign link.cmd_err = cerr_ff;
    assign link.cmd_byte = byte_ff;
    assign O_BUSY = busy_ff;

    // --------------------------------------------------------------
    // Response frame receiver
    // --------------------------------------------------------------
    assign r_idx = link.rsp_sof ? 8'h00 : r_idx_ff;
    assign r_crc_nx = bfc_pkg::crc_byte(link.rsp_sof ? bfc_pkg::CRC_INIT : r_crc_ff,
                                        link.rsp_byte);

    // Track length from the count field, check residue at the end
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            r_act_ff <= 1'b0;
            r_idx_ff <= 8'h00;
            r_len_ff <= 8'h00;
            r_crc_ff <= bfc_pkg::CRC_INIT;
            O_RSP_VLD <= 1'b0;
            O_RSP_SOF <= 1'b0;
            O_RSP_BYTE <= 8'h00;
            O_RSP_END <= 1'b0;
            O_RSP_CRC_OK <= 1'b0;
        end
        else
        begin
            O_RSP_VLD <= link.rsp_vld && (r_act_ff || link.rsp_sof);
            O_RSP_SOF <= link.rsp_vld && link.rsp_sof;
            O_RSP_BYTE <= link.rsp_byte;
            O_RSP_END <= 1'b0;
            if (link.rsp_vld && (r_act_ff || link.rsp_sof))
            begin
                r_crc_ff <= r_crc_nx;
                r_idx_ff <= r_idx + 8'h01;
                r_act_ff <= 1'b1;
                if (link.rsp_sof)
                    r_len_ff <= bfc_pkg::rsp_len(link.rsp_byte[6:0]);
                else if (r_idx == r_len_ff - 8'h01)
                begin
                    r_act_ff <= 1'b0;
                    O_RSP_END <= 1'b1;
                    O_RSP_CRC_OK <= (r_crc_nx == bfc_pkg::CRC_GOOD);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bfc_dev_end.sv ====
`default_nettype none
module bfc_dev_end (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    bfc_link_if.device link,
    input wire logic [5:0] I_OWN_ADDR,
    input wire logic I_TOP_OF_STACK,
    input wire logic I_ADDR_OK,
    input wire logic [7:0] I_RD_DATA,
    input wire logic I_FLAG_CLR,
    input wire logic I_CHN_VLD,
    input wire logic I_CHN_SOF,
    input wire logic [7:0] I_CHN_BYTE,
    output var logic O_CHN_VLD,
    output var logic O_CHN_SOF,
    output var logic [7:0] O_CHN_BYTE,
    output var logic [15:0] O_CUR_ADDR,
    output var logic O_WR_STB,
    output var logic [2:0] O_WR_REQ,
    output var logic [3:0] O_WR_LEN,
    output var logic [63:0] O_WR_DATA,
    output var logic O_RSVD_INIT_ERR,
    output var logic O_FRAME_START_ERR,
    output var logic O_CHAR_ERR,
    output var logic O_CMD_CRC_ERR,
    output var logic O_RSP_CRC_ERR
);
    // --------------------------------------------------------------
    // Command receiver
    // --------------------------------------------------------------
    logic rx_act_ff, rx_bad_ff;
    logic [7:0] rx_idx_ff, rx_len_ff, idx, hdr, d, b;
    logic [15:0] crc_ff, crc_nx;
    logic [2:0] req_ff, req_c, size_ff;
    logic [5:0] dev_ff;
    logic [6:0] rcnt_ff;
    logic [7:0] reg_hi_ff;
    logic [15:0] base_ff;
    logic take, last, good, addressed;
    logic set_rsvd, set_sof, set_char, set_cmd_crc, set_rsp_crc;

    assign b = link.cmd_byte;
    assign idx = link.cmd_sof ? 8'h00 : rx_idx_ff;
    assign req_c = link.cmd_sof ? b[6:4] : req_ff;
    assign hdr = bfc_pkg::has_dev(req_c) ? 8'h02 : 8'h01;
    assign d = idx - hdr - 8'h02;
    assign crc_nx = bfc_pkg::crc_byte(link.cmd_sof ? bfc_pkg::CRC_INIT : crc_ff, b);
    assign take = link.cmd_vld && !link.cmd_sof && rx_act_ff;
    assign last = take && (idx == rx_len_ff - 8'h01);
    assign good = last && !rx_bad_ff && !link.cmd_err && (crc_nx == bfc_pkg::CRC_GOOD);
    assign addressed = !bfc_pkg::has_dev(req_ff) || (dev_ff == I_OWN_ADDR);
    assign set_rsvd = link.cmd_vld && link.cmd_sof && b[bfc_pkg::INIT_TYPE_BIT]
                      && (b[6:4] == bfc_pkg::REQ_RSVD);
    // A new start mid-frame, a stray byte, or a response-type init
    assign set_sof = link.cmd_vld && ((link.cmd_sof && (rx_act_ff ||
                     !b[bfc_pkg::INIT_TYPE_BIT])) || (!link.cmd_sof && !rx_act_ff));
    assign set_char = link.cmd_vld && link.cmd_err;
    assign set_cmd_crc = last && !rx_bad_ff && !link.cmd_err && !good;

    // Frame tracking and field capture
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rx_act_ff <= 1'b0;
            rx_bad_ff <= 1'b0;
            rx_idx_ff <= 8'h00;
            rx_len_ff <= 8'h00;
            crc_ff <= bfc_pkg::CRC_INIT;
            req_ff <= 3'h0;
            size_ff <= 3'h0;
            dev_ff <= 6'h00;
            rcnt_ff <= 7'h00;
            reg_hi_ff <= 8'h00;
            base_ff <= 16'h0000;
            O_WR_DATA <= 64'h0;
        end
        else if (link.cmd_vld && (link.cmd_sof || rx_act_ff))
        begin
            crc_ff <= crc_nx;
            rx_idx_ff <= idx + 8'h01;
            if (link.cmd_sof)
            begin
                rx_act_ff <= b[bfc_pkg::INIT_TYPE_BIT];
                req_ff <= b[6:4];
                size_ff <= b[2:0];
                rx_bad_ff <= link.cmd_err || (b[6:4] == bfc_pkg::REQ_RSVD);
                rx_len_ff <= bfc_pkg::cmd_len(b[6:4], b[2:0]);
            end
            else
            begin
                rx_bad_ff <= rx_bad_ff || link.cmd_err;
                if (last)
                    rx_act_ff <= 1'b0;
                // alias values from 0x4f up to top address
                if (idx == 8'h01 && hdr == 8'h02)
                    dev_ff <= (b >= bfc_pkg::DEV_ALIAS_LO) ? bfc_pkg::DEV_ADDR_MAX : b[5:0];
                if (idx == hdr)
                    reg_hi_ff <= b;
                if (idx == hdr + 8'h01)
                    base_ff <= {reg_hi_ff, b};
                if (idx >= hdr + 8'h02 && idx < rx_len_ff - 8'h02)
                begin
                    rcnt_ff <= b[6:0];
                    O_WR_DATA[{d[2:0], 3'b000} +: 8] <= b;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Forwarding toward the chain
    // --------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_CHN_VLD <= 1'b0;
            O_CHN_SOF <= 1'b0;
            O_CHN_BYTE <= 8'h00;
        end
        else
        begin
            O_CHN_VLD <= link.cmd_vld && !link.cmd_err;
            O_CHN_SOF <= link.cmd_sof;
            O_CHN_BYTE <= b;
        end
    end

    // --------------------------------------------------------------
    // Chain response monitor
    // --------------------------------------------------------------
    logic c_act_ff;
    logic [7:0] c_idx_ff, c_len_ff, c_idx;
    logic [15:0] c_crc_ff, c_crc_nx;
    logic c_take, c_last, c_good;

    assign c_take = I_CHN_VLD && (I_CHN_SOF || c_act_ff);
    assign c_idx = I_CHN_SOF ? 8'h00 : c_idx_ff;
    assign c_crc_nx = bfc_pkg::crc_byte(I_CHN_SOF ? bfc_pkg::CRC_INIT : c_crc_ff, I_CHN_BYTE);
    assign c_last = c_take && !I_CHN_SOF && (c_idx == c_len_ff - 8'h01);
    assign c_good = c_last && (c_crc_nx == bfc_pkg::CRC_GOOD);
    assign set_rsp_crc = c_last && !c_good;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            c_act_ff <= 1'b0;
            c_idx_ff <= 8'h00;
            c_len_ff <= 8'h00;
            c_crc_ff <= bfc_pkg::CRC_INIT;
        end
        else if (c_take)
        begin
            c_crc_ff <= c_crc_nx;
            c_idx_ff <= c_idx + 8'h01;
            c_act_ff <= !c_last;
            if (I_CHN_SOF)
                c_len_ff <= bfc_pkg::rsp_len(I_CHN_BYTE[6:0]);
        end
    end

    // --------------------------------------------------------------
    // Own response and write execution
    // --------------------------------------------------------------
    logic pend_ff, tx_act_ff, go;
    logic [7:0] tx_idx_ff, tx_len_ff, sel;
    logic [15:0] tcrc_ff;
    logic rsp_vld_ff, rsp_sof_ff;
    logic [7:0] rsp_byte_ff;

    assign go = (good && bfc_pkg::is_read(req_ff) && addressed
                 && (bfc_pkg::has_dev(req_ff) || I_TOP_OF_STACK)) || (pend_ff && c_good);

    always_comb
    begin
        if (tx_idx_ff == 8'h00)
            sel = {1'b0, rcnt_ff};
        else if (tx_idx_ff == 8'h01)
            sel = {2'b00, I_OWN_ADDR};
        else if (tx_idx_ff == 8'h02)
            sel = base_ff[15:8];
        else if (tx_idx_ff == 8'h03)
            sel = base_ff[7:0];
        else if (tx_idx_ff < tx_len_ff - 8'h02)
            sel = I_ADDR_OK ? I_RD_DATA : bfc_pkg::RD_INVALID_DATA;
        else if (tx_idx_ff == tx_len_ff - 8'h02)
            sel = tcrc_ff[7:0];
        else
            sel = tcrc_ff[15:8];
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            pend_ff <= 1'b0;
            tx_act_ff <= 1'b0;
            tx_idx_ff <= 8'h00;
            tx_len_ff <= 8'h00;
            tcrc_ff <= bfc_pkg::CRC_INIT;
            O_CUR_ADDR <= 16'h0000;
            O_WR_STB <= 1'b0;
            O_WR_REQ <= 3'h0;
            O_WR_LEN <= 4'h0;
        end
        else
        begin
            O_WR_STB <= good && !bfc_pkg::is_read(req_ff) && addressed && I_ADDR_OK;
            O_WR_REQ <= req_ff;
            O_WR_LEN <= {1'b0, size_ff} + 4'h1;
            if (take && idx == hdr + 8'h01)
                O_CUR_ADDR <= {reg_hi_ff, b};
            // Stacked reads wait for the frame from above
            if (good && bfc_pkg::is_read(req_ff) && addressed && !go)
                pend_ff <= 1'b1;
            // bad frame from above cancels append
            else if (set_rsp_crc || go)
                pend_ff <= 1'b0;
            if (go)
            begin
                tx_act_ff <= 1'b1;
                tx_idx_ff <= 8'h00;
                tx_len_ff <= bfc_pkg::rsp_len(rcnt_ff);
                tcrc_ff <= bfc_pkg::CRC_INIT;
                O_CUR_ADDR <= base_ff;
            end
            else if (tx_act_ff)
            begin
                if (tx_idx_ff < tx_len_ff - 8'h02)
                    tcrc_ff <= bfc_pkg::crc_byte(tcrc_ff, sel);
                tx_idx_ff <= tx_idx_ff + 8'h01;
                if (tx_idx_ff >= 8'h04 && tx_idx_ff < tx_len_ff - 8'h02)
                    O_CUR_ADDR <= O_CUR_ADDR + 16'h0001;
                if (tx_idx_ff == tx_len_ff - 8'h01)
                    tx_act_ff <= 1'b0;
            end
        end
    end

    // Response channel: own frame, else chain bytes forwarded as they are
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rsp_vld_ff <= 1'b0;
            rsp_sof_ff <= 1'b0;
            rsp_byte_ff <= 8'h00;
        end
        else if (tx_act_ff)
        begin
            rsp_vld_ff <= 1'b1;
            rsp_sof_ff <= (tx_idx_ff == 8'h00);
            rsp_byte_ff <= sel;
        end
        else
        begin
            rsp_vld_ff <= I_CHN_VLD;
            rsp_sof_ff <= I_CHN_SOF;
            rsp_byte_ff <= I_CHN_BYTE;
        end
    end

    assign link.rsp_vld = rsp_vld_ff;
    assign link.rsp_sof = rsp_sof_ff;
    assign link.rsp_byte = rsp_byte_ff;

    // --------------------------------------------------------------
    // Sticky error flags, set wins over clear
    // --------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_RSVD_INIT_ERR <= 1'b0;
            O_FRAME_START_ERR <= 1'b0;
            O_CHAR_ERR <= 1'b0;
            O_CMD_CRC_ERR <= 1'b0;
            O_RSP_CRC_ERR <= 1'b0;
        end
        else
        begin
            O_RSVD_INIT_ERR <= set_rsvd || (O_RSVD_INIT_ERR && !I_FLAG_CLR);
            O_FRAME_START_ERR <= set_sof || (O_FRAME_START_ERR && !I_FLAG_CLR);
            O_CHAR_ERR <= set_char || (O_CHAR_ERR && !I_FLAG_CLR);
            // each device flags its own fault
            O_CMD_CRC_ERR <= set_cmd_crc || (O_CMD_CRC_ERR && !I_FLAG_CLR);
            O_RSP_CRC_ERR <= set_rsp_crc || (O_RSP_CRC_ERR && !I_FLAG_CLR);
        end
    end
endmodule
`default_nettype wire

// ==== bfc_link_chk.sv ====
`default_nettype none
module bfc_link_chk (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic cmd_vld,
    input wire logic cmd_sof,
    input wire logic cmd_err,
    input wire logic [7:0] cmd_byte,
    input wire logic rsp_vld,
    input wire logic rsp_sof,
    input wire logic [7:0] rsp_byte
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic [15:0] crc_ff;

    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'ha001 : c >> 1;
        return c;
    endfunction

    // Residue over the whole command frame, restarted by each start byte
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            crc_ff <= 16'hffff;
        else if (cmd_vld)
            crc_ff <= crc(cmd_sof ? 16'hffff : crc_ff, cmd_byte);
    end

    // ----------------------------------------------------------
    // Frame properties
    // ----------------------------------------------------------
    sequence s_cmd7;
        cmd_vld ##1 (cmd_vld && !cmd_sof)[*6] ##1 !cmd_vld;
    endsequence
    sequence s_rsp7;
        rsp_vld ##1 (rsp_vld && !rsp_sof)[*6] ##1 !rsp_vld;
    endsequence
    property p_cmd_type; cmd_sof |-> cmd_vld && cmd_byte[7]; endproperty
    property p_rsp_type; rsp_sof |-> rsp_vld && !rsp_byte[7]; endproperty
    property p_rd_size; cmd_sof && cmd_byte[6:4] inside {0, 2, 4} |-> cmd_byte[3:0] == 0;
    endproperty
    property p_wr1_len; cmd_sof && cmd_byte == 8'h90 |-> s_cmd7; endproperty
    property p_rsp1_len; rsp_sof && rsp_byte == 8'h00 |-> s_rsp7; endproperty
    property p_dev_byte; cmd_sof && cmd_byte[6:5] == 0 |=> cmd_vld && cmd_byte[7:6] == 0;
    endproperty
    property p_rsp_dev; rsp_sof |=> rsp_vld && rsp_byte[7:6] == 0; endproperty
    property p_cmd_crc; cmd_vld ##1 !cmd_vld |-> crc_ff == 16'h0000; endproperty
    a_cmd_type: assert property (p_cmd_type) else $error("bad command init");
    a_rsp_type: assert property (p_rsp_type) else $error("bad response init");
    a_rd_size: assert property (p_rd_size) else $error("read size not zero");
    a_wr1_len: assert property (p_wr1_len) else $error("write frame length");
    a_rsp1_len: assert property (p_rsp1_len) else $error("response length");
    a_dev_byte: assert property (p_dev_byte) else $error("command address byte");
    a_rsp_dev: assert property (p_rsp_dev) else $error("response address byte");
    a_cmd_crc: assert property (p_cmd_crc) else $error("command residue");
endmodule
`default_nettype wire

// ==== tb_bridge_frame_codec_crc.sv ====
`default_nettype none
module tb_bridge_frame_codec_crc;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, start = 0, mark = 0, fclr = 0;
    logic [2:0] req = 0, size = 0, wreq;
    logic [5:0] dev = 0;
    logic [15:0] ra = 0, cur;
    logic [63:0] data = 0, wdat;
    logic busy, rvld, rend, crok, wstb, rsof, fvld;
    logic [4:0] fl;
    logic [7:0] rbyte;
    logic [3:0] wlen;
    logic [7:0] q8[$];
    logic [74:0] qw[$];
    int miscompares = 0, n_tests = 0, cyc = 0, nfwd = 0, nsof = 0;
    bfc_link_if i_bfc_link_if ();
    bfc_host_end i_bfc_host_end (.I_CLK(clk), .I_SYS_RST(rst), .link(i_bfc_link_if),
        .I_START(start), .I_REQ(req), .I_DEV_ADDR(dev), .I_REG_ADDR(ra), .I_SIZE(size),
        .I_DATA(data), .I_MARK_ERR(mark), .O_BUSY(busy), .O_RSP_VLD(rvld), .O_RSP_SOF(rsof),
        .O_RSP_BYTE(rbyte), .O_RSP_END(rend), .O_RSP_CRC_OK(crok));
    bfc_dev_end i_bfc_dev_end (.I_CLK(clk), .I_SYS_RST(rst), .link(i_bfc_link_if),
        .I_OWN_ADDR(6'h05), .I_TOP_OF_STACK(1'b1), .I_ADDR_OK(cur < 16'h1000),
        .I_RD_DATA(cur[7:0] ^ 8'h5a), .I_FLAG_CLR(fclr), .I_CHN_VLD(1'b0), .I_CHN_SOF(1'b0),
        .I_CHN_BYTE(8'h00), .O_CHN_VLD(fvld), .O_CHN_SOF(), .O_CHN_BYTE(), .O_CUR_ADDR(cur),
        .O_WR_STB(wstb), .O_WR_REQ(wreq), .O_WR_LEN(wlen), .O_WR_DATA(wdat),
        .O_RSVD_INIT_ERR(fl[4]), .O_FRAME_START_ERR(fl[3]), .O_CHAR_ERR(fl[2]),
        .O_CMD_CRC_ERR(fl[1]), .O_RSP_CRC_ERR(fl[0]));
    bfc_link_chk i_bfc_link_chk (.I_CLK(clk), .I_SYS_RST(rst),
        .cmd_vld(i_bfc_link_if.cmd_vld), .cmd_sof(i_bfc_link_if.cmd_sof),
        .cmd_err(i_bfc_link_if.cmd_err), .cmd_byte(i_bfc_link_if.cmd_byte),
        .rsp_vld(i_bfc_link_if.rsp_vld), .rsp_sof(i_bfc_link_if.rsp_sof),
        .rsp_byte(i_bfc_link_if.rsp_byte));

    initial forever #5 clk = ~clk;

    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'ha001 : c >> 1;
        return c;
    endfunction

    task automatic chk(input logic [74:0] seen, input logic [74:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One command; waits for the frame and any expected answer, bounded
    task automatic send(input logic [2:0] r, input logic [5:0] d, input logic [15:0] a,
        input logic [2:0] s, input logic [63:0] x);
        @(posedge clk);
        {start, req, dev, ra, size, data} <= {1'b1, r, d, a, s, x};
        @(posedge clk);
        start <= 1'b0;
        #1;
        for (int i = 0; i < 400 && (busy !== 1'b0 || q8.size() > 0); i++)
            @(posedge clk) #1;
        chk(busy, 1'b0);
        repeat (3) @(posedge clk);
    endtask

    // Whole expected answer: header, data (zero past the valid range), residue
    task automatic exp_rd(input logic [15:0] a, input logic [7:0] n);
        logic [15:0] c = 16'hffff;
        logic [15:0] t;
        logic [7:0] b[$];
        b = '{{1'b0, n[6:0]}, 8'h05, a[15:8], a[7:0]};
        for (int k = 0; k <= n[6:0]; k++)
        begin
            t = a + 16'(k);
            b.push_back(t < 16'h1000 ? t[7:0] ^ 8'h5a : 8'h00);
        end
        foreach (b[i])
            c = crc(c, b[i]);
        q8 = {q8, b, c[7:0], c[15:8]};
    endtask

    // Oldest note against each result; cycle ceiling cuts a hang
    always @(negedge clk)
    begin
        if (rvld)
            chk(rbyte, q8.size() ? q8.pop_front() : 'x);
        if (rend)
            chk(crok, 1'b1);
        if (wstb)
            chk({wreq, wlen, wdat & ~('1 << (8 * wlen))}, qw.size() ? qw.pop_front() : 'x);
        // Forwarded command bytes and response starts, checked as counts
        nfwd += fvld;
        nsof += rsof;
        if (++cyc > 30000)
        begin
            miscompares++;
            summarize();
        end
    end

    initial
    begin
        logic [2:0] s;
        static logic [2:0] wr[4] = '{bfc_pkg::REQ_SGL_WR, bfc_pkg::REQ_STK_WR, bfc_pkg::REQ_BC_WR,
            bfc_pkg::REQ_BC_WRR};
        logic [63:0] x;
        int n0;
        void'($urandom(42));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            s = 3'($urandom);
            x = {$urandom, $urandom};
            qw.push_back({wr[k % 4], 4'(s) + 4'h1, x & ~('1 << (8 * (s + 1)))});
            send(wr[k % 4], 6'h05, 16'($urandom) & 16'h0fff, s, x);
        end
        chk(fl, 5'h00);
        $display("test writes done");
        // Bad address, foreign device, reserved code, damaged bytes: nothing written
        send(bfc_pkg::REQ_SGL_WR, 6'h05, 16'hf000, 3'h0, 64'h1);
        n0 = nfwd;
        send(bfc_pkg::REQ_SGL_WR, 6'h06, 16'h0010, 3'h0, 64'h1);
        chk(nfwd - n0, 7);
        send(bfc_pkg::REQ_RSVD, 6'h05, 16'h0010, 3'h0, 64'h1);
        chk(fl, 5'h10);
        n0 = nfwd;
        mark <= 1'b1;
        send(bfc_pkg::REQ_STK_WR, 6'h05, 16'h0010, 3'h0, 64'h1);
        mark <= 1'b0;
        chk(nfwd, n0);
        chk(fl, 5'h14);
        fclr <= 1'b1;
        @(posedge clk) fclr <= 1'b0;
        $display("test refusals done");
        // Every read kind; count top bit ignored; range crosses invalid space
        exp_rd(16'h0020, 8'h80);
        send(bfc_pkg::REQ_SGL_RD, 6'h05, 16'h0020, 3'h0, 64'h80);
        exp_rd(16'h0ff0, 8'h9f);
        send(bfc_pkg::REQ_STK_RD, 6'h05, 16'h0ff0, 3'h0, 64'h9f);
        x = 64'($urandom & 8'hff);
        exp_rd(16'h0100, x[7:0]);
        send(bfc_pkg::REQ_BC_RD, 6'h05, 16'h0100, 3'h0, x);
        chk({fl, q8.size()}, 0);
        chk(nsof, 3);
        $display("test reads done");
        summarize();
    end
endmodule
`default_nettype wire
